// ### bank1_regs.sv
// Bank-1 special register map behind an APB slave
//
// What this block does
// - Unimplemented addresses and bits read as zero and ignore writes.
// - Only the program counter low byte is in the map; its upper bits are not.
// - A 5-bit buffer holds counter bits 12..8 and is copied in only on a low-byte write.
// - Window, counter low byte, status, pointer, buffer and interrupt control decode from every bank.
// - The window address reads or writes data memory at the pointer, not a register.
// - The option register loads all ones on power-on or brown-out reset.
//
// Bus timing: a setup cycle, then two access cycles; pready rises in the second.
// The wait state lets a window read launched in setup come back out of the
// memory's output flop before read data is captured, so every index answers
// alike and the read mux never waits on the memory array itself.
// Writes land at the edge that completes the transfer; read data is captured
// after the first access cycle and stays on prdata until the next read.
// A low clock enable freezes the handshake as well: a low pready waits, but once pready is high the transfer completes and its write is dropped.
// Limitation: the window reaches 256 bytes at the pointer; the bank-select
// bits of the status do not widen it.
`timescale 1ns/1ns
`default_nettype none
module bank1_regs #(
  parameter int MEM_AW = bank1_pkg::MEM_AW
) (
  // Clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bank1_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Core and peripheral side
  input  wire logic                        pc_advance,
  input  wire bank1_pkg::hw_in_t           hw_in,
  output bank1_pkg::regs_t                 cfg,
  output logic      [bank1_pkg::PC_W-1:0]  pc,
  output logic      [bank1_pkg::BUF_W-1:0] upper_address_buffer
);

  bank1_pkg::regs_t regs_q;
  bank1_pkg::regs_t regs_d;

  logic                      ack_q;
  logic                      ack_d;
  logic [7:0]                rdat_q;
  logic [7:0]                rdat_d;
  logic [7:0]                rd_c;
  logic [bank1_pkg::IDX_W-1:0] idx;
  logic                      setup;
  logic                      first_acc;
  logic                      done;
  logic                      wr;
  logic [7:0]                wb;
  logic                      win_blocked;
  logic                      mem_rd;
  logic                      mem_wr;
  logic [7:0]                mem_rdata;
  logic [bank1_pkg::PC_W-1:0]  pc_q;
  logic [bank1_pkg::BUF_W-1:0] buf_q;
  // Mirrored core registers, decoded once
  logic                      sel_window;
  logic                      sel_pclow;
  logic                      sel_status;
  logic                      sel_pointer;
  logic                      sel_upbuf;
  logic                      sel_intctl;

  // Address match; mirrored registers ignore the bank bits
  function automatic logic hit(input logic [bank1_pkg::IDX_W-1:0] a,
                               input logic [7:0] off,
                               input logic mirrored);
    if (mirrored) begin
      hit = (a[6:0] == off[6:0]);
    end else begin
      hit = (a == {1'b0, off});
    end
  endfunction : hit

  // Pointer naming the window itself blocks the memory write and reads zero
  function automatic logic self_ref(input logic [7:0] p);
    self_ref = (p[6:0] == bank1_pkg::IDX_WINDOW[6:0]);
  endfunction : self_ref

  // Software bits from the write, hardware-only bits kept
  function automatic logic [7:0] merge(input logic [7:0] w,
                                       input logic [7:0] old,
                                       input logic [7:0] mask);
    merge = (w & mask) | (old & ~mask);
  endfunction : merge

  // Core registers answer at the same low index in every bank
  assign sel_window  = hit(idx, bank1_pkg::IDX_WINDOW, 1'b1);
  assign sel_pclow   = hit(idx, bank1_pkg::IDX_PCLOW, 1'b1);
  assign sel_status  = hit(idx, bank1_pkg::IDX_STATUS, 1'b1);
  assign sel_pointer = hit(idx, bank1_pkg::IDX_POINTER, 1'b1);
  assign sel_upbuf   = hit(idx, bank1_pkg::IDX_UPBUF, 1'b1);
  assign sel_intctl  = hit(idx, bank1_pkg::IDX_INTCTL, 1'b1);

  // APB phases; one wait state lets the memory read settle in a flop
  assign idx         = paddr[bank1_pkg::ADDR_W-1:2];
  assign setup       = psel && !penable;
  assign first_acc   = psel && penable && !ack_q;
  assign done        = psel && penable && ack_q;
  assign wr          = done && pwrite;
  assign wb          = pwdata[7:0];
  assign pready      = penable && ack_q;
  assign pslverr     = 1'b0;
  assign prdata      = {24'h000000, rdat_q};
  assign win_blocked = self_ref(regs_q.pointer);

  // Indirect window goes to memory at the pointer
  assign mem_rd = setup && !pwrite && sel_window;
  assign mem_wr = wr && sel_window && !win_blocked;

  data_ram #(
    .AW (MEM_AW),
    .DW (8)
  ) u_ram (
    .pclk    (pclk),
    .ce      (ce),
    .rd_en   (mem_rd),
    .wr_en   (mem_wr),
    .addr    (regs_q.pointer[MEM_AW-1:0]),
    .wdata   (wb),
    .rdata_q (mem_rdata)
  );

  // Counter low byte in the map, upper bits only through the buffer
  pc_unit #(
    .PC_W  (bank1_pkg::PC_W),
    .BUF_W (bank1_pkg::BUF_W)
  ) u_pc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .advance (pc_advance),
    .low_we  (wr && sel_pclow),
    .buf_we  (wr && sel_upbuf),
    .wdata   (wb),
    .pc_q    (pc_q),
    .buf_q   (buf_q)
  );

  assign pc                   = pc_q;
  assign upper_address_buffer = buf_q;
  assign cfg                  = regs_q;

  // Read mux; anything not decoded reads zero
  always_comb begin
    rd_c = 8'h00;
    if (sel_window) begin
      rd_c = win_blocked ? 8'h00 : mem_rdata;
    end else if (sel_pclow) begin
      rd_c = pc_q[7:0];
    end else if (sel_status) begin
      rd_c = regs_q.status;
    end else if (sel_pointer) begin
      rd_c = regs_q.pointer;
    end else if (sel_upbuf) begin
      rd_c = {3'b000, buf_q};
    end else if (sel_intctl) begin
      rd_c = regs_q.intctl;
    end else if (hit(idx, bank1_pkg::IDX_OPTION, 1'b0)) begin
      rd_c = regs_q.option;
    end else if (hit(idx, bank1_pkg::IDX_PORT_A_DIRECTION, 1'b0)) begin
      rd_c = {2'b00, regs_q.port_a_direction};
    end else if (hit(idx, bank1_pkg::IDX_PORT_B_DIRECTION, 1'b0)) begin
      rd_c = regs_q.port_b_direction;
    end else if (hit(idx, bank1_pkg::IDX_PORT_C_DIRECTION, 1'b0)) begin
      rd_c = regs_q.port_c_direction;
    end else if (hit(idx, bank1_pkg::IDX_PERIPHERAL_IRQ_ENABLE_ONE, 1'b0)) begin
      rd_c = regs_q.peripheral_irq_enable_one & bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_ONE;
    end else if (hit(idx, bank1_pkg::IDX_PERIPHERAL_IRQ_ENABLE_TWO, 1'b0)) begin
      rd_c = regs_q.peripheral_irq_enable_two & bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_TWO;
    end else if (hit(idx, bank1_pkg::IDX_RCAUSE, 1'b0)) begin
      rd_c = {6'b000000, regs_q.rcause};
    end else if (hit(idx, bank1_pkg::IDX_SSPCTL2, 1'b0)) begin
      rd_c = regs_q.sspctl2;
    end else if (hit(idx, bank1_pkg::IDX_PERIOD, 1'b0)) begin
      rd_c = regs_q.period;
    end else if (hit(idx, bank1_pkg::IDX_SSPADDR, 1'b0)) begin
      rd_c = regs_q.sspaddr;
    end else if (hit(idx, bank1_pkg::IDX_SERIAL_PORT_STATE, 1'b0)) begin
      rd_c = {regs_q.serial_port_state_ctl, hw_in.ssp_state};
    end else if (hit(idx, bank1_pkg::IDX_CONVERTER_RESULT_LOW, 1'b0)) begin
      rd_c = hw_in.conv_low;
    end else if (hit(idx, bank1_pkg::IDX_ADCFG1, 1'b0)) begin
      rd_c = regs_q.adcfg1 & bank1_pkg::MASK_ADCFG1;
    end
  end

  // Handshake and read data capture
  always_comb begin
    ack_d  = ack_q ? 1'b0 : (psel && penable);
    rdat_d = rdat_q;
    if (first_acc && !pwrite) begin
      rdat_d = rd_c;
    end
  end

  // Register writes, then hardware events; hardware wins a tie
  always_comb begin
    regs_d = regs_q;
    if (wr) begin
      // Mirrored core registers
      if (sel_status) begin
        // Timeout and power-down bits are hardware-only
        regs_d.status = merge(wb, regs_q.status, bank1_pkg::MASK_STATUS_W);
      end
      if (sel_pointer) begin
        regs_d.pointer = wb;
      end
      if (sel_intctl) begin
        regs_d.intctl = wb;
      end
      // Bank-1 only registers
      if (hit(idx, bank1_pkg::IDX_OPTION, 1'b0)) begin
        regs_d.option = wb;
      end
      if (hit(idx, bank1_pkg::IDX_PORT_A_DIRECTION, 1'b0)) begin
        regs_d.port_a_direction = wb[5:0];
      end
      if (hit(idx, bank1_pkg::IDX_PORT_B_DIRECTION, 1'b0)) begin
        regs_d.port_b_direction = wb;
      end
      if (hit(idx, bank1_pkg::IDX_PORT_C_DIRECTION, 1'b0)) begin
        regs_d.port_c_direction = wb;
      end
      if (hit(idx, bank1_pkg::IDX_PERIPHERAL_IRQ_ENABLE_ONE, 1'b0)) begin
        regs_d.peripheral_irq_enable_one = wb & bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_ONE;
      end
      if (hit(idx, bank1_pkg::IDX_PERIPHERAL_IRQ_ENABLE_TWO, 1'b0)) begin
        regs_d.peripheral_irq_enable_two = wb & bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_TWO;
      end
      if (hit(idx, bank1_pkg::IDX_RCAUSE, 1'b0)) begin
        regs_d.rcause = wb[1:0];
      end
      if (hit(idx, bank1_pkg::IDX_SSPCTL2, 1'b0)) begin
        regs_d.sspctl2 = merge(wb, regs_q.sspctl2, bank1_pkg::MASK_SSPCTL2_W);
      end
      if (hit(idx, bank1_pkg::IDX_PERIOD, 1'b0)) begin
        regs_d.period = wb;
      end
      if (hit(idx, bank1_pkg::IDX_SSPADDR, 1'b0)) begin
        regs_d.sspaddr = wb;
      end
      if (hit(idx, bank1_pkg::IDX_SERIAL_PORT_STATE, 1'b0)) begin
        regs_d.serial_port_state_ctl = wb[7:bank1_pkg::SERIAL_PORT_STATE_CTL_LO];
      end
      if (hit(idx, bank1_pkg::IDX_ADCFG1, 1'b0)) begin
        regs_d.adcfg1 = wb & bank1_pkg::MASK_ADCFG1;
      end
    end
    // Core results overwrite a simultaneous software write
    if (hw_in.alu_we) begin
      regs_d.status[2:0] = hw_in.alu_flags;
    end
    if (hw_in.wdt_timeout) begin
      regs_d.status[bank1_pkg::STATUS_TO] = 1'b0;
    end
    if (hw_in.sleep_entry) begin
      regs_d.status[bank1_pkg::STATUS_PD] = 1'b0;
    end
    // Interrupt flags: a set in the clearing cycle is kept
    regs_d.intctl = regs_d.intctl | ({5'b00000, hw_in.irq_set} & bank1_pkg::MASK_INT_FLAGS);
    if (hw_in.bor_event) begin
      regs_d.rcause[bank1_pkg::RCAUSE_BOR] = 1'b0;
    end
    regs_d.sspctl2[bank1_pkg::SSPCTL2_ACKSTS] = hw_in.ack_status;
  end

  // Defined values load on power-on or brown-out reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_q <= bank1_pkg::REGS_RST;
    end else if (ce) begin
      regs_q <= regs_d;
    end
  end

  // Handshake flop and captured read data; cleared so no word from before reset shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q  <= 1'b0;
      rdat_q <= 8'h00;
    end else if (ce) begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

endmodule : bank1_regs
`default_nettype wire

// ### bank1_pkg.sv
// Package: offsets, masks, reset values and carrier structs of the bank-1 register map
package bank1_pkg;

  // APB address width; byte address = 4 * register index
  localparam int ADDR_W = 11;
  localparam int IDX_W  = 9;
  localparam int DW     = 8;
  localparam int PC_W   = 13;
  localparam int BUF_W  = 5;
  localparam int MEM_AW = 8;

  // Register indices
  localparam logic [7:0] IDX_WINDOW  = 8'h80;
  localparam logic [7:0] IDX_OPTION  = 8'h81;
  localparam logic [7:0] IDX_PCLOW   = 8'h82;
  localparam logic [7:0] IDX_STATUS  = 8'h83;
  localparam logic [7:0] IDX_POINTER = 8'h84;
  localparam logic [7:0] IDX_PORT_A_DIRECTION   = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION   = 8'h86;
  localparam logic [7:0] IDX_PORT_C_DIRECTION   = 8'h87;
  localparam logic [7:0] IDX_UPBUF   = 8'h8a;
  localparam logic [7:0] IDX_INTCTL  = 8'h8b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE_ONE    = 8'h8c;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE_TWO    = 8'h8d;
  localparam logic [7:0] IDX_RCAUSE  = 8'h8e;
  localparam logic [7:0] IDX_SSPCTL2 = 8'h91;
  localparam logic [7:0] IDX_PERIOD  = 8'h92;
  localparam logic [7:0] IDX_SSPADDR = 8'h93;
  localparam logic [7:0] IDX_SERIAL_PORT_STATE = 8'h94;
  localparam logic [7:0] IDX_CONVERTER_RESULT_LOW  = 8'h9e;
  localparam logic [7:0] IDX_ADCFG1  = 8'h9f;

  // Writable bit masks and hardware-set interrupt flags; other enable and ADCFG1 bits read zero, other status and SSPCTL2 bits stay hardware-owned
  localparam logic [7:0] MASK_STATUS_W  = 8'he7;
  localparam logic [7:0] MASK_PERIPHERAL_IRQ_ENABLE_ONE      = 8'h4f;
  localparam logic [7:0] MASK_PERIPHERAL_IRQ_ENABLE_TWO      = 8'h18;
  localparam logic [7:0] MASK_ADCFG1    = 8'h8f;
  localparam logic [7:0] MASK_SSPCTL2_W = 8'hbf;
  localparam logic [7:0] MASK_INT_FLAGS = 8'h07;

  // Bit positions
  localparam int STATUS_TO      = 4;
  localparam int STATUS_PD      = 3;
  localparam int RCAUSE_POR     = 1;
  localparam int RCAUSE_BOR     = 0;
  localparam int SSPCTL2_ACKSTS = 6;
  localparam int SERIAL_PORT_STATE_CTL_LO = 6;

  // Register state carried to the peripherals and core
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [5:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic [7:0] intctl;
    logic [7:0] peripheral_irq_enable_one;
    logic [7:0] peripheral_irq_enable_two;
    logic [1:0] rcause;
    logic [7:0] sspctl2;
    logic [7:0] period;
    logic [7:0] sspaddr;
    logic [1:0] serial_port_state_ctl;
    logic [7:0] adcfg1;
  } regs_t;

  // Hardware events and read-only status from the core and peripherals
  typedef struct packed {
    logic       alu_we;
    logic [2:0] alu_flags;
    logic       wdt_timeout;
    logic       sleep_entry;
    logic [2:0] irq_set;
    logic       bor_event;
    logic       ack_status;
    logic [5:0] ssp_state;
    logic [7:0] conv_low;
  } hw_in_t;

  // Power-on / brown-out values
  localparam regs_t REGS_RST = '{
    option: 8'hff, status: 8'h18, pointer: 8'h00, port_a_direction: 6'h3f,
    port_b_direction: 8'hff, port_c_direction: 8'hff, intctl: 8'h00, peripheral_irq_enable_one: 8'h00,
    peripheral_irq_enable_two: 8'h00, rcause: 2'h0, sspctl2: 8'h00, period: 8'hff,
    sspaddr: 8'h00, serial_port_state_ctl: 2'h0, adcfg1: 8'h00};

endpackage : bank1_pkg

// ### data_ram.sv
// Data memory reached through the indirect window, registered read
`timescale 1ns/1ns
`default_nettype none
module data_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          pclk,
  input  wire logic          ce,
  // Access
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [2**AW];

  // Contents are unknown after reset, as the device documents
  always_ff @(posedge pclk) begin
    if (ce && wr_en) begin
      mem[addr] <= wdata;
    end
    if (ce && rd_en) begin
      rdata_q <= mem[addr];
    end
  end

endmodule : data_ram
`default_nettype wire

// ### pc_unit.sv
// Program counter with low-byte load and upper-address holding buffer
`timescale 1ns/1ns
`default_nettype none
module pc_unit #(
  parameter int PC_W  = 13,
  parameter int BUF_W = 5
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Core and bus strobes
  input  wire logic             advance,
  input  wire logic             low_we,
  input  wire logic             buf_we,
  input  wire logic [7:0]       wdata,
  // State
  output logic      [PC_W-1:0]  pc_q,
  output logic      [BUF_W-1:0] buf_q
);

  logic [PC_W-1:0]  pc_d;
  logic [BUF_W-1:0] buf_d;

  // Low-byte write jumps, taking the upper bits from the buffer
  always_comb begin
    pc_d  = pc_q;
    buf_d = buf_q;
    if (buf_we) begin
      buf_d = wdata[BUF_W-1:0];
    end
    if (low_we) begin
      pc_d = {buf_q, wdata};
    end else if (advance) begin
      pc_d = pc_q + PC_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q  <= '0;
      buf_q <= '0;
    end else if (ce) begin
      pc_q  <= pc_d;
      buf_q <= buf_d;
    end
  end

endmodule : pc_unit
`default_nettype wire

// ### bank1_regs_chk.sv
// Checker: bus answers and register relations of the bank-1 map
`timescale 1ns/1ns
`default_nettype none
module bank1_regs_chk (
  // Clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // APB
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [bank1_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // Core side
  input wire logic                         pc_advance,
  input wire bank1_pkg::regs_t             cfg,
  input wire logic [bank1_pkg::PC_W-1:0]   pc,
  input wire logic [bank1_pkg::BUF_W-1:0]  upper_address_buffer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed transfers; low seven index bits select within any bank
  wire [8:0] idx     = paddr[10:2];
  wire       rd_done = psel && penable && pready && !pwrite;
  wire       wr_done = psel && penable && pready && pwrite;

  // Map holes read zero; bank-1 PC upper byte has no index
  a_unmapped_zero: assert property (rd_done && idx inside {9'h088, 9'h089, 9'h08f, 9'h090, [9'h095:9'h09d]}
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_no_error: assert property (psel && penable && pready |-> !pslverr) else $error("error response");
  a_pie_reserved: assert property (((cfg.peripheral_irq_enable_one & ~bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_ONE) == 8'h0)
    && ((cfg.peripheral_irq_enable_two & ~bank1_pkg::MASK_PERIPHERAL_IRQ_ENABLE_TWO) == 8'h0)) else $error("reserved enable bit set");
  a_upper_read_zero: assert property (rd_done && idx[6:0] == 7'h0a |-> prdata[31:5] == 27'h0)
    else $error("buffer top bits not zero");
  // Buffer write leaves the counter alone; low-byte write loads both parts
  a_buffer_holds: assert property (wr_done && idx[6:0] == 7'h0a && !pc_advance
    |=> pc == $past(pc) && upper_address_buffer == $past(pwdata[4:0])) else $error("buffer write moved counter");
  a_lowbyte_load: assert property (wr_done && idx[6:0] == 7'h02 && !pc_advance
    |=> pc == {$past(upper_address_buffer), $past(pwdata[7:0])}) else $error("low byte load wrong");
  a_pointer_mirror: assert property (wr_done && idx[6:0] == 7'h04
    |=> cfg.pointer == $past(pwdata[7:0])) else $error("pointer not written");
  a_window_no_reg: assert property (wr_done && idx[6:0] == 7'h00
    |=> $stable({cfg.pointer, cfg.option, cfg.port_b_direction})) else $error("window write hit a register");
  a_option_reset: assert property ($rose(presetn) |-> cfg.option == 8'hff)
    else $error("option not all ones after reset");

  // Main scenarios reached
  c_window_read: cover property (rd_done && idx[6:0] == 7'h00);
  c_buffer_write: cover property (wr_done && idx == 9'h08a);
  c_reset_release: cover property ($rose(presetn));
endmodule : bank1_regs_chk

bind bank1_regs bank1_regs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pc_advance(pc_advance), .cfg(cfg), .pc(pc), .upper_address_buffer(upper_address_buffer));
`default_nettype wire

// ### bank1_regs_bench.sv
// Testbench: bank-1 map reset values, holes, masks, mirrors and window over APB
`timescale 1ns/1ns
`default_nettype none
module bank1_regs_bench;
  logic                        pclk       = 1'b0;
  logic                        presetn    = 1'b0;
  logic                        psel       = 1'b0;
  logic                        penable    = 1'b0;
  logic                        pwrite     = 1'b0;
  logic                        pc_advance = 1'b0;
  logic [10:0]                 paddr      = 11'h0;
  logic [31:0]                 pwdata     = 32'h0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic [bank1_pkg::PC_W-1:0]  pc;
  logic [bank1_pkg::BUF_W-1:0] upper_address_buffer;
  bank1_pkg::regs_t            cfg;
  logic [31:0]                 exp_q[$];
  int                          fails        = 0;
  int                          total_checks = 0;
  logic [15:0]                 rnd          = 16'hd8f7;
  logic [7:0]                  d1;
  logic [7:0]                  d2;
  // Reset values, then holes and masked bits after writing all ones, or 8'h4f and 8'hbe to the two enables
  logic [8:0] rst_idx [11] = '{9'h081, 9'h082, 9'h085, 9'h086, 9'h087, 9'h08a, 9'h091, 9'h092, 9'h093, 9'h094, 9'h09f};
  logic [7:0] rst_val [11] = '{8'hff, 8'h00, 8'h3f, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [8:0] msk_idx [10] = '{9'h088, 9'h089, 9'h08f, 9'h090, 9'h095, 9'h09d, 9'h08c, 9'h08d, 9'h09f, 9'h085};
  logic [7:0] msk_val [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4f, 8'h18, 8'h8f, 8'h3f};
  // Reserved interrupt-enable bits are written zero at 9'h08c and partly one at 9'h08d
  logic [7:0] msk_wr  [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h4f, 8'hbe, 8'hff, 8'hff};

  // Core events stay quiet; ce always runs
  bank1_regs dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_advance(pc_advance),
    .hw_in('0), .cfg(cfg), .pc(pc), .upper_address_buffer(upper_address_buffer));

  always #5 pclk = ~pclk;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  // Expected read data is noted before the transfer starts
  task automatic rd(input logic [8:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(1'b0, idx, 8'h00);
  endtask : rd

  // Oldest note against read data at the completing edge
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, exp_q.pop_front());
  end

  // Hang guard, well above the few hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(rst_idx[i], rst_val[i]);
    for (int i = 0; i < 10; i++) begin
      wr(msk_idx[i], msk_wr[i]);
      rd(msk_idx[i], msk_val[i]);
    end
    // Buffer does not move the counter until a low-byte write
    wr(9'h08a, 8'hff);
    rd(9'h08a, 8'h1f);
    chk(32'(pc), 32'h0);
    chk(32'(upper_address_buffer), 32'h1f);
    rnd = lfsr(rnd);
    d1  = rnd[7:0];
    wr(9'h182, d1);
    @(posedge pclk);
    chk(32'(pc), 32'({5'h1f, d1}));
    pc_advance <= 1'b1;
    @(posedge pclk);
    pc_advance <= 1'b0;
    @(posedge pclk);
    chk(32'(pc), 32'(13'({5'h1f, d1}) + 13'h1));
    rd(9'h002, d1 + 8'h1);
    // Status and interrupt control reached from other banks
    wr(9'h103, 8'hff);
    rd(9'h083, 8'hff);
    wr(9'h003, 8'h00);
    rd(9'h183, 8'h18);
    wr(9'h00b, 8'ha5);
    rd(9'h10b, 8'ha5);
    // Window goes to memory at the pointer, from any bank
    rnd = lfsr(rnd);
    d1  = rnd[7:0];
    rnd = lfsr(rnd);
    d2  = rnd[7:0];
    wr(9'h184, 8'h20);
    wr(9'h080, d1);
    wr(9'h004, 8'h21);
    wr(9'h100, d2);
    wr(9'h084, 8'h20);
    rd(9'h080, d1);
    rd(9'h104, 8'h20);
    wr(9'h084, 8'h21);
    rd(9'h180, d2);
    rd(9'h001, 8'h00);
    // Mid-run reset brings the option back to all ones
    wr(9'h081, 8'h00);
    rd(9'h081, 8'h00);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(9'h081, 8'hff);
    rd(9'h08a, 8'h00);
    print_verdict;
  end
endmodule : bank1_regs_bench
`default_nettype wire
